// file: hdl/ulc_cfg.svh
`ifndef ULC_CFG_SVH
`define ULC_CFG_SVH
// register byte offsets
`define ULC_OFF_IBRD 12'h024
`define ULC_OFF_FBRD 12'h028
`define ULC_OFF_LCR 12'h02c
`define ULC_OFF_CTL 12'h030
`define ULC_OFF_STAT 12'h03c
`define ULC_OFF_TXD 12'h040
`define ULC_OFF_RXD 12'h044
// line control fields
`define ULC_LCR_BRK 0
`define ULC_LCR_PEN 1
`define ULC_LCR_EPS 2
`define ULC_LCR_TWO_STOP_SELECT 3
`define ULC_LCR_FEN 4
`define ULC_LCR_WLO 5
`define ULC_LCR_SPS 7
// port control fields and reset value
`define ULC_CTL_EN 0
`define ULC_CTL_LBE 7
`define ULC_CTL_TXE 8
`define ULC_CTL_RXE 9
`define ULC_CTL_RST 10'h300
// oversampling per bit
`define ULC_OVS 5'd16
`endif

// file: hdl/ulc_pkg.sv
package ulc_pkg;
   typedef enum logic [2:0] {ULC_IDLE, ULC_START, ULC_DATA, ULC_PAR, ULC_STOP} ulc_st_t;
endpackage

// file: hdl/ulc_top.sv
// Our own choice: the APB interface to the registers.
`include "ulc_cfg.svh"
// Summary of operation
// [RL1] divisor takes effect on line control write
// [RL2] stick parity with even select sends zero
// [RL3] stick parity with odd select sends one
// [RL4] word length field selects five to eight
// [RL5] fifo enable else one byte holding
// [RL6] two stop bits sent when selected
// [RL7] receiver checks only first stop bit
// [RL8] even select gives even ones count
// [RL9] even select ignored without parity enable
// [RL10] parity enable adds and checks parity
// [RL11] break holds line low after character
// [RL12] software holds break two characters
// [RL13] reset clears all but tx rx enables
// [RL14] port idle unless global enable set; break still drives the line low while the port is disabled
// [RL15] software disables port before reconfiguring
// [RL16] disable finishes current character first
// [RL17] new divisor waits for character end
// [RL18] tx rx enables gated by global enable
// [RL19] loopback routes serial out to input
module ulc_top
   import ulc_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // serial line
   input wire logic i_serial_in,
   output logic o_serial_out
);
   localparam int DEPTH = 16;
   // register state
   logic [15:0] ibrd_q, ibrd_d, fbrd_q, fbrd_d;
   logic [15:0] div_act_q, div_act_d, div_pend_q, div_pend_d;
   logic [5:0] frac_act_q, frac_act_d, frac_pend_q, frac_pend_d;
   logic [7:0] lcr_q, lcr_d;
   logic [9:0] ctl_q, ctl_d;
   logic wr, rd, tx_busy, rx_busy, tx_pop, rx_push;
   logic [7:0] rx_word;
   logic rx_perr, rx_ferr;
   // fifo storage, flops addressed by index
   logic [7:0] txm_q [DEPTH];
   logic [9:0] rxe_q [DEPTH];
   logic [3:0] txw_q, txw_d, txr_q, txr_d, rxw_q, rxw_d, rxr_q, rxr_d;
   logic [4:0] txc_q, txc_d, rxc_q, rxc_d;
   logic [4:0] cap;
   logic en, tx_on, rx_on;

   assign wr = i_psel && i_penable && i_pwrite;
   assign rd = i_psel && i_penable && !i_pwrite;
   assign o_pready = 1'b1;
   assign en = ctl_q[`ULC_CTL_EN];
   assign tx_on = en && ctl_q[`ULC_CTL_TXE]; // [RL14] [RL18]
   assign rx_on = en && ctl_q[`ULC_CTL_RXE]; // [RL14] [RL18]
   assign cap = lcr_q[`ULC_LCR_FEN] ? 5'd16 : 5'd1; // [RL5]

   // unmapped addresses answer with an error
   always_comb begin
      unique case (i_paddr)
         `ULC_OFF_IBRD, `ULC_OFF_FBRD, `ULC_OFF_LCR, `ULC_OFF_CTL,
         `ULC_OFF_STAT, `ULC_OFF_TXD, `ULC_OFF_RXD: o_pslverr = 1'b0;
         default: o_pslverr = i_psel && i_penable;
      endcase
   end

   // register writes and divisor staging
   always_comb begin
      ibrd_d = ibrd_q;
      fbrd_d = fbrd_q;
      lcr_d = lcr_q;
      ctl_d = ctl_q;
      div_pend_d = div_pend_q;
      frac_pend_d = frac_pend_q;
      div_act_d = div_act_q;
      frac_act_d = frac_act_q;
      if (wr && i_paddr == `ULC_OFF_IBRD) ibrd_d = i_pwdata[15:0];
      if (wr && i_paddr == `ULC_OFF_FBRD) fbrd_d = {10'h000, i_pwdata[5:0]};
      if (wr && i_paddr == `ULC_OFF_LCR) begin
         lcr_d = i_pwdata[7:0];
         div_pend_d = ibrd_q; // [RL1]
         frac_pend_d = fbrd_q[5:0]; // [RL1]
      end
      if (wr && i_paddr == `ULC_OFF_CTL) begin
         ctl_d = {i_pwdata[9:7], 6'h00, i_pwdata[0]};
      end
      // only swap rate between characters, so no frame mixes two rates
      if (!tx_busy && !rx_busy) begin
         div_act_d = div_pend_q; // [RL17]
         frac_act_d = frac_pend_q; // [RL17]
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ibrd_q <= 16'h0000;
         fbrd_q <= 16'h0000;
         lcr_q <= 8'h00;
         ctl_q <= `ULC_CTL_RST; // [RL13]
         div_pend_q <= 16'h0000;
         frac_pend_q <= 6'h00;
         div_act_q <= 16'h0000;
         frac_act_q <= 6'h00;
      end else begin
         ibrd_q <= ibrd_d;
         fbrd_q <= fbrd_d;
         lcr_q <= lcr_d;
         ctl_q <= ctl_d;
         div_pend_q <= div_pend_d;
         frac_pend_q <= frac_pend_d;
         div_act_q <= div_act_d;
         frac_act_q <= frac_act_d;
      end
   end

   // fractional 16x tick: divisor in 64ths, min ratio one
   logic [21:0] bacc_q, bacc_d;
   logic tick;
   logic [21:0] bstep;
   assign bstep = {div_act_q, frac_act_q};
   always_comb begin
      tick = 1'b0;
      bacc_d = bacc_q + 22'h000040;
      if (div_act_q == 16'h0000 || bacc_d >= bstep) begin
         tick = 1'b1;
         bacc_d = (div_act_q == 16'h0000) ? 22'h000000 : bacc_d - bstep;
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) bacc_q <= 22'h000000;
      else bacc_q <= bacc_d;
   end

   // fifo pointers; in character mode capacity is one
   logic tx_push, rx_pop;
   assign tx_push = wr && i_paddr == `ULC_OFF_TXD && txc_q < cap;
   assign rx_pop = rd && i_paddr == `ULC_OFF_RXD && rxc_q != 5'd0;
   always_comb begin
      txw_d = txw_q + 4'(tx_push);
      txr_d = txr_q + 4'(tx_pop);
      txc_d = txc_q + 5'(tx_push) - 5'(tx_pop);
      rxw_d = rxw_q + 4'(rx_push);
      rxr_d = rxr_q + 4'(rx_pop);
      rxc_d = rxc_q + 5'(rx_push) - 5'(rx_pop);
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         txw_q <= 4'h0;
         txr_q <= 4'h0;
         txc_q <= 5'h00;
         rxw_q <= 4'h0;
         rxr_q <= 4'h0;
         rxc_q <= 5'h00;
      end else begin
         txw_q <= txw_d;
         txr_q <= txr_d;
         txc_q <= txc_d;
         rxw_q <= rxw_d;
         rxr_q <= rxr_d;
         rxc_q <= rxc_d;
      end
   end
   generate
      for (genvar g = 0; g < DEPTH; g++) begin : g_mem
         always_ff @(posedge i_mclk) begin
            if (tx_push && txw_q == 4'(g)) txm_q[g] <= i_pwdata[7:0];
            if (rx_push && rxw_q == 4'(g)) begin
               rxe_q[g] <= {rx_ferr, rx_perr, rx_word};
            end
         end
      end
   endgenerate

   // read mux
   always_comb begin
      o_prdata = 32'h00000000;
      if (rd) begin
         unique case (i_paddr)
            `ULC_OFF_IBRD: o_prdata = {16'h0000, ibrd_q};
            `ULC_OFF_FBRD: o_prdata = {26'h0000000, fbrd_q[5:0]};
            `ULC_OFF_LCR: o_prdata = {24'h000000, lcr_q};
            `ULC_OFF_CTL: o_prdata = {22'h000000, ctl_q};
            `ULC_OFF_STAT: o_prdata = {26'h0000000, rx_busy, tx_busy, rxc_q != 5'd0, txc_q >= cap,
                                       rxc_q >= cap, txc_q == 5'd0};
            `ULC_OFF_RXD: o_prdata = {22'h000000, rxe_q[rxr_q]};
            default: o_prdata = 32'h00000000;
         endcase
      end
   end

   // parity value from data and line control
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] l);
      logic [7:0] m;
      m = d & ((l[6:5] == 2'h3) ? 8'hff : (l[6:5] == 2'h2) ? 8'h7f : (l[6:5] == 2'h1) ? 8'h3f : 8'h1f); // [RL4]
      if (l[`ULC_LCR_SPS]) par_bit = !l[`ULC_LCR_EPS]; // [RL2] [RL3]
      else par_bit = (^m) ^ !l[`ULC_LCR_EPS]; // [RL8]
   endfunction

   // transmitter; frame format latched at start so edits cannot tear it
   ulc_st_t ts_q, ts_d;
   logic [3:0] tph_q, tph_d;
   logic [2:0] tbit_q, tbit_d;
   logic [7:0] tsh_q, tsh_d, tl_q, tl_d;
   logic tstp_q, tstp_d, tout_q, tout_d;
   assign tx_busy = ts_q != ULC_IDLE;
   always_comb begin
      ts_d = ts_q;
      tph_d = tph_q;
      tbit_d = tbit_q;
      tsh_d = tsh_q;
      tl_d = tl_q;
      tstp_d = tstp_q;
      tout_d = tout_q;
      tx_pop = 1'b0;
      if (ts_q == ULC_IDLE) begin
         tout_d = !(lcr_q[`ULC_LCR_BRK]); // [RL11]
         if (tx_on && txc_q != 5'd0 && tick && !lcr_q[`ULC_LCR_BRK]) begin // [RL14]
            tx_pop = 1'b1;
            tsh_d = txm_q[txr_q];
            tl_d = lcr_q;
            ts_d = ULC_START;
            tph_d = 4'h0;
            tout_d = 1'b0;
         end
      end else if (tick) begin
         tph_d = tph_q + 4'h1;
         if (tph_q == 4'hf) begin
            unique case (ts_q)
               ULC_START: begin
                  ts_d = ULC_DATA;
                  tbit_d = 3'h0;
                  tout_d = tsh_q[0];
               end
               ULC_DATA: begin
                  tbit_d = tbit_q + 3'h1;
                  tout_d = tsh_q[3'(tbit_q + 3'h1)];
                  if (tbit_q == 3'(3'd4 + tl_q[6:5])) begin // [RL4]
                     ts_d = tl_q[`ULC_LCR_PEN] ? ULC_PAR : ULC_STOP; // [RL10] [RL9]
                     tout_d = tl_q[`ULC_LCR_PEN] ? par_bit(tsh_q, tl_q) : 1'b1;
                     tstp_d = tl_q[`ULC_LCR_TWO_STOP_SELECT];
                  end
               end
               ULC_PAR: begin
                  ts_d = ULC_STOP;
                  tout_d = 1'b1;
               end
               default: begin
                  // second stop bit when selected, then finish
                  if (tstp_q) tstp_d = 1'b0; // [RL6]
                  else begin
                     ts_d = ULC_IDLE; // [RL16]
                     tout_d = !(lcr_q[`ULC_LCR_BRK]);
                  end
               end
            endcase
         end
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ts_q <= ULC_IDLE;
         tph_q <= 4'h0;
         tbit_q <= 3'h0;
         tsh_q <= 8'h00;
         tl_q <= 8'h00;
         tstp_q <= 1'b0;
         tout_q <= 1'b1;
      end else begin
         ts_q <= ts_d;
         tph_q <= tph_d;
         tbit_q <= tbit_d;
         tsh_q <= tsh_d;
         tl_q <= tl_d;
         tstp_q <= tstp_d;
         tout_q <= tout_d;
      end
   end
   // loopback keeps the pin idle-high while internally wired
   assign o_serial_out = ctl_q[`ULC_CTL_LBE] ? 1'b1 : tout_q;

   // receive input: two flops, then loopback select
   logic rs1_q, rs2_q, rin;
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rs1_q <= 1'b1;
         rs2_q <= 1'b1;
      end else begin
         rs1_q <= i_serial_in;
         rs2_q <= rs1_q;
      end
   end
   assign rin = ctl_q[`ULC_CTL_LBE] ? tout_q : rs2_q; // [RL19]

   // receiver samples mid-bit
   ulc_st_t rs_q, rs_d;
   logic [3:0] rph_q, rph_d;
   logic [2:0] rbit_q, rbit_d;
   logic [7:0] rsh_q, rsh_d, rl_q, rl_d;
   logic rpe_q, rpe_d;
   assign rx_busy = rs_q != ULC_IDLE;
   always_comb begin
      rs_d = rs_q;
      rph_d = rph_q;
      rbit_d = rbit_q;
      rsh_d = rsh_q;
      rl_d = rl_q;
      rpe_d = rpe_q;
      rx_push = 1'b0;
      rx_word = rsh_q;
      rx_perr = rpe_q;
      rx_ferr = !rin;
      if (rs_q == ULC_IDLE) begin
         if (rx_on && tick && !rin) begin // [RL14]
            rs_d = ULC_START;
            rph_d = 4'h0;
            rl_d = lcr_q;
            rsh_d = 8'h00;
            rpe_d = 1'b0;
         end
      end else if (tick) begin
         rph_d = rph_q + 4'h1;
         if (rph_q == 4'h7) begin
            unique case (rs_q)
               ULC_START: begin
                  rs_d = rin ? ULC_IDLE : ULC_DATA; // glitch rejection
                  rbit_d = 3'h0;
                  rph_d = 4'h8;
               end
               ULC_DATA: begin
                  rsh_d[rbit_q] = rin;
                  rbit_d = rbit_q + 3'h1;
                  if (rbit_q == 3'(3'd4 + rl_q[6:5])) begin // [RL4]
                     rs_d = rl_q[`ULC_LCR_PEN] ? ULC_PAR : ULC_STOP; // [RL10] [RL9]
                  end
               end
               ULC_PAR: begin
                  rpe_d = rin != par_bit(rsh_q, rl_q); // [RL8] [RL2] [RL3]
                  rs_d = ULC_STOP;
               end
               default: begin
                  // only first stop bit checked; second is just idle time
                  rs_d = ULC_IDLE; // [RL7] [RL16]
                  rx_push = rxc_q < cap; // [RL5]
               end
            endcase
         end
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rs_q <= ULC_IDLE;
         rph_q <= 4'h0;
         rbit_q <= 3'h0;
         rsh_q <= 8'h00;
         rl_q <= 8'h00;
         rpe_q <= 1'b0;
      end else begin
         rs_q <= rs_d;
         rph_q <= rph_d;
         rbit_q <= rbit_d;
         rsh_q <= rsh_d;
         rl_q <= rl_d;
         rpe_q <= rpe_d;
      end
   end
endmodule

// file: tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h0, fb, fe;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic o_pready, o_pslverr, i_serial_in, o_serial_out, er, bad;
   logic [7:0] d0, d1, cfg[6];
   int n_fail = 0, check_count = 0, cyc = 0, gap, nb;
   integer seed = 32'hfe655dbf;
   ulc_top dut_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_serial_in(i_serial_in), .o_serial_out(o_serial_out));
   ulc_peer peer_u (.i_mclk(i_mclk), .i_line(o_serial_out), .o_line(i_serial_in));
   initial forever #12.5 i_mclk = ~i_mclk;
   // cut a hang short
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done;
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k = 0;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do @(posedge i_mclk); while (o_pready !== 1'b1 && ++k < 64);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // reference frame, lsb first, stop bits and beyond at one
   function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] c, output int n);
      logic [11:0] f = '1;
      int w = 5 + int'(c[6:5]);
      d = d & (8'hff >> (2'd3 - c[6:5]));
      f[0] = 1'b0;
      for (int i = 0; i < w; i++) f[i + 1] = d[i];
      n = w + 1;
      if (c[1]) begin
         f[n] = c[7] ? ~c[2] : ~^{c[2], d};
         n++;
      end
      n += c[3] ? 2 : 1;
      return f;
   endfunction
   initial begin
      cfg = '{8'h10, 8'h36, 8'h5a, 8'hf6, 8'hf2, 8'h1c};
      repeat (12) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      apb(1'b0, 12'h02c, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      chk(rd, 32'h300);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("reset test done");
      foreach (cfg[j]) begin
         d0 = 8'($random(seed));
         d1 = 8'($random(seed));
         bad = 1'($random(seed)) & cfg[j][1];
         apb(1'b1, 12'h030, 32'h300);
         apb(1'b1, 12'h02c, {24'h0, cfg[j]});
         apb(1'b0, 12'h02c, 32'h0);
         chk(rd, {24'h0, cfg[j]});
         apb(1'b1, 12'h040, {24'h0, d0});
         apb(1'b1, 12'h040, {24'h0, d1});
         peer_u.grab(12, 400, fb, gap);
         chk(gap, -1);
         apb(1'b1, 12'h030, 32'h301);
         fe = frame(d0, cfg[j], nb);
         peer_u.grab(nb, 100, fb, gap);
         chk(fb, fe);
         fe = frame(d1, cfg[j], nb);
         peer_u.grab(nb, 100, fb, gap);
         chk(fb, fe);
         chk((gap + 2) / 4, nb * 4);
         fe = frame(d0, cfg[j] & 8'hf7, nb);
         fe[nb - 2] ^= bad;
         peer_u.send(fe, nb);
         peer_u.send(fe, nb);
         repeat (20) @(posedge i_mclk);
         repeat (2) begin
            apb(1'b0, 12'h044, 32'h0);
            chk(rd, {22'h0, 1'b0, bad, d0 & (8'hff >> (2'd3 - cfg[j][6:5]))});
         end
         $display("format %h test done", cfg[j]);
      end
      d0 = 8'($random(seed));
      apb(1'b1, 12'h02c, 32'h70);
      apb(1'b1, 12'h040, {24'h0, d0});
      apb(1'b1, 12'h02c, 32'h71);
      fe = frame(d0, 8'h70, nb);
      peer_u.grab(nb, 100, fb, gap);
      chk(fb, fe);
      repeat (500) @(posedge i_mclk);
      chk({31'h0, o_serial_out}, 32'h0);
      apb(1'b1, 12'h02c, 32'h70);
      repeat (4) @(posedge i_mclk);
      chk({31'h0, o_serial_out}, 32'h1);
      $display("break test done");
      apb(1'b1, 12'h030, 32'h381);
      d0 = 8'($random(seed));
      apb(1'b1, 12'h040, {24'h0, d0});
      repeat (300) @(posedge i_mclk);
      apb(1'b0, 12'h044, 32'h0);
      chk(rd, {24'h0, d0});
      $display("loopback test done");
      test_done;
   end
endmodule

// file: tb/ulc_checker.sv
`include "ulc_cfg.svh"
module ulc_checker (
   // apb
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // line
   input wire logic o_serial_out
);
   logic [7:0] lcr_q, lcr_d;
   logic [9:0] ctl_q, ctl_d, brk_q, brk_d, off_q, off_d;
   logic acc, wr;
   assign acc = i_psel && i_penable;
   assign wr = acc && i_pwrite;
   // shadows; counts saturate, 256 outlasts a frame at the fastest rate only
   always_comb begin
      lcr_d = (wr && i_paddr == 12'h02c) ? i_pwdata[7:0] : lcr_q;
      ctl_d = (wr && i_paddr == 12'h030) ? i_pwdata[9:0] & 10'h381 : ctl_q;
      brk_d = (lcr_q[0] && ctl_q[0] && !ctl_q[7]) ? brk_q + {9'h0, ~&brk_q} : 10'h0;
      off_d = (!ctl_q[0] && !lcr_q[0]) ? off_q + {9'h0, ~&off_q} : 10'h0;
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lcr_q <= 8'h0;
         ctl_q <= `ULC_CTL_RST;
         brk_q <= 10'h0;
         off_q <= 10'h0;
      end else begin
         lcr_q <= lcr_d;
         ctl_q <= ctl_d;
         brk_q <= brk_d;
         off_q <= off_d;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   lcr_read_a: assert property (acc && !i_pwrite && i_paddr == 12'h02c |-> o_prdata == {24'h0, lcr_q})
      else $error("line control readback wrong");
   ctl_read_a: assert property (acc && !i_pwrite && i_paddr == 12'h030 |-> o_prdata == {22'h0, ctl_q})
      else $error("port control readback wrong");
   loop_high_a: assert property (ctl_q[7] && $past(ctl_q[7]) |-> o_serial_out)
      else $error("pin not high in loopback");
   break_low_a: assert property (brk_q >= 10'd256 && lcr_q[0] |-> !o_serial_out)
      else $error("break not driven low");
   off_idle_a: assert property (off_q >= 10'd256 && !ctl_q[0] |-> o_serial_out)
      else $error("line active while disabled");
   err_map_a: assert property (acc |-> o_pslverr == !(i_paddr inside {12'h024, 12'h028, 12'h02c,
      12'h030, 12'h03c, 12'h040, 12'h044})) else $error("slave error wrong");
   rd_idle_a: assert property (!acc |-> o_prdata == 32'h0)
      else $error("read data outside access");
   wait_free_a: assert property (i_psel |-> o_pready)
      else $error("ready low");
endmodule
bind ulc_top ulc_checker chk_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_serial_out(o_serial_out));

// file: tb/ulc_peer.sv
module ulc_peer #(
   parameter int BP = 16
) (
   input wire logic i_mclk,
   input wire logic i_line,
   output logic o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   time last = 0;
   initial o_line = 1'b1;
   // frame ends on a stop bit, so the line already rests high after it
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         o_line <= f[i];
         repeat (BP) @(posedge i_mclk);
      end
   endtask
   // returns at the middle of the last bit, before the next start edge
   task automatic grab(input int n, input int lim, output logic [11:0] f, output int gap);
      int w = 0;
      f = '1;
      gap = -1;
      while (w < lim && i_line !== 1'b0) begin
         @(posedge i_mclk);
         w++;
      end
      if (w < lim) begin
         gap = int'(($time - last) / 25);
         last = $time;
         for (int i = 0; i < n; i++) begin
            repeat (i == 0 ? BP / 2 : BP) @(posedge i_mclk);
            f[i] = i_line;
         end
      end
   endtask
endmodule
